/* verilog/uef_pkg.sv */
// Constants and types for the endpoint FIFO register block
package uef_pkg;

   localparam logic [7:0] UEF_ENDPOINT_CONTROL_OFS   = 8'h21;
   localparam logic [7:0] UEF_ENDPOINT_RECEIVE_STATUS_OFS  = 8'h22;
   localparam logic [7:0] UEF_RECEIVE_FIFO_DATA_OFS   = 8'h23;
   localparam logic [7:0] UEF_RECEIVE_FIFO_CONTROL_OFS   = 8'h24;
   localparam logic [7:0] UEF_RECEIVE_BYTE_COUNT_OFS   = 8'h26;
   localparam logic [7:0] UEF_EPSEL_OFS   = 8'h31;
   localparam logic [7:0] UEF_ENDPOINT_TRANSMIT_STATUS_OFS  = 8'h32;
   localparam logic [7:0] UEF_TRANSMIT_FIFO_DATA_OFS   = 8'h33;
   localparam logic [7:0] UEF_TRANSMIT_FIFO_CONTROL_OFS   = 8'h34;
   localparam logic [7:0] UEF_DEVCTL_OFS  = 8'h3e;
   localparam logic [7:0] UEF_LPMSTAT_OFS = 8'h3f;

   // Bit positions inside the registers
   localparam int UEF_B_RX_STALL  = 7;
   localparam int UEF_B_TX_STALL  = 6;
   localparam int UEF_B_RX_ON     = 2;
   localparam int UEF_B_TX_ON     = 0;
   localparam int UEF_B_TOGGLE    = 7;
   localparam int UEF_B_SETUP     = 6;
   localparam int UEF_B_SETUP_START_OVERWRITE     = 5;
   localparam int UEF_B_SETUP_END_OVERWRITE     = 4;
   localparam int UEF_B_TOG_OVW   = 3;
   localparam int UEF_B_FLUSH     = 7;
   localparam int UEF_B_RELEASE   = 4;
   localparam int UEF_B_TX_ERR    = 1;
   localparam int UEF_B_EP2_DIR   = 0;

   localparam int         UEF_FIFO_DEPTH = 8;
   localparam logic [3:0] UEF_FIFO_FULL  = 4'h8;
   localparam int         UEF_NUM_EP     = 3;

   // Resume duration and latency codes, in microseconds
   localparam int UEF_HIRD_BASE_US = 50;
   localparam int UEF_HIRD_STEP_US = 75;
   localparam int UEF_BESL_US [16] = '{125, 150, 200, 300, 400, 500,
      1000, 2000, 3000, 4000, 5000, 6000, 7000, 8000, 9000,
      10000};

   typedef enum logic [1:0] {UEF_TOK_OUT, UEF_TOK_IN, UEF_TOK_SETUP}
      uef_tok_type;

   typedef enum logic [1:0] {UEF_HS_NONE, UEF_HS_ACK, UEF_HS_NAK,
      UEF_HS_STALL} uef_hs_code_type;

   typedef struct packed {
      logic            valid;
      uef_hs_code_type code;
   } uef_hs_type;

   // Events from the packet engine
   typedef struct packed {
      logic        tok;
      uef_tok_type kind;
      logic [1:0]  ep;
      logic        rx_stb;
      logic [7:0]  rx_byte;
      logic        rx_end;
      logic        tx_take;
      logic        in_ack;
      logic        tx_tmo;
      logic        lpm_ack;
      logic [4:0]  lpm_attr;
   } uef_link_in_type;

   typedef struct packed {
      logic                                rx_stall;
      logic                                tx_stall;
      logic                                rx_on;
      logic                                tx_on;
      logic                                rx_tog;
      logic                                tx_tog;
      logic                                tx_err;
      logic                                tx_ready;
      logic                                rx_full;
      logic [3:0]                          rx_cnt;
      logic [2:0]                          rx_rd;
      logic [3:0]                          tx_cnt;
      logic [2:0]                          tx_rd;
      logic [UEF_FIFO_DEPTH-1:0][7:0]      rx_mem;
      logic [UEF_FIFO_DEPTH-1:0][7:0]      tx_mem;
   } uef_ep_type;

   typedef struct packed {
      uef_ep_type [UEF_NUM_EP-1:0] ep;
      logic [1:0]                  sel;
      logic                        ep2_dir;
      logic                        setup;
      logic                        setup_start_overwrite;
      logic                        setup_end_overwrite;
      logic [4:0]                  lpm;
      logic [1:0]                  cur_ep;
      uef_tok_type                 cur_kind;
      logic                        cur_ok;
      uef_hs_type                  hs;
      logic [7:0]                  tx_byte;
      logic                        tx_odd;
      logic [7:0]                  rdata;
   } uef_state_type;

   function automatic uef_state_type uef_state_reset();
      uef_state_type r;
      r = '0;
      r.ep[0].rx_on = 1'b1;
      r.ep[0].tx_on = 1'b1;
      return r;
   endfunction : uef_state_reset

   localparam uef_state_type UEF_STATE_RST = uef_state_reset();

endpackage : uef_pkg

/* verilog/uef_endpoint_regs.sv */
// Endpoint-indexed control, status and FIFO registers
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module uef_endpoint_regs
   import uef_pkg::*;
(
   input  wire logic            CLK,        // System clock, 10 MHz
   input  wire logic            SYS_RST,    // System reset, sync, high
   input  wire logic            USB_RST,    // Bus reset, sync, high
   input  wire logic            CE,         // Clock enable, freezes all but reset
   input  wire logic [7:0]      ADDR,       // Register address
   input  wire logic [7:0]      WDATA,      // Register write data
   input  wire logic            WR,         // Write strobe
   input  wire logic            RD,         // Read strobe
   output      logic [7:0]      RDATA,      // Read data, cycle after RD
   input  wire uef_link_in_type LINK_IN,    // Packet engine events
   output      uef_hs_type      HS,         // Handshake verdict
   output      logic [7:0]      TX_BYTE,    // Byte handed to link
   output      logic            TX_PID_ODD  // Data PID toggle for IN
);

   uef_state_type s_r;
   uef_state_type s_nxt;
   logic [1:0]    sel;
   logic [1:0]    te;
   logic [1:0]    ce;
   logic          rx_ok;
   logic          tx_ok;

   function automatic logic has_rx(input logic [1:0] i, input logic d);
      return (i == 2'd0) || (i == 2'd2 && d);
   endfunction : has_rx

   function automatic logic has_tx(input logic [1:0] i, input logic d);
      return (i == 2'd0) || (i == 2'd1) || (i == 2'd2 && !d);
   endfunction : has_tx

   assign sel   = s_r.sel;
   assign te    = LINK_IN.ep;
   assign ce    = s_r.cur_ep;
   assign rx_ok = has_rx(sel, s_r.ep2_dir);
   assign tx_ok = has_tx(sel, s_r.ep2_dir);

   always_comb begin
      s_nxt          = s_r;
      s_nxt.hs.valid = 1'b0;
      s_nxt.rdata    = 8'h00;

      // Register reads
      if (RD) begin
         unique case (ADDR)
            UEF_ENDPOINT_CONTROL_OFS: begin
               if (rx_ok) begin
                  s_nxt.rdata[UEF_B_RX_STALL] = s_r.ep[sel].rx_stall;
                  s_nxt.rdata[UEF_B_RX_ON]    = s_r.ep[sel].rx_on;
               end
               if (tx_ok) begin
                  s_nxt.rdata[UEF_B_TX_STALL] = s_r.ep[sel].tx_stall;
                  s_nxt.rdata[UEF_B_TX_ON]    = s_r.ep[sel].tx_on;
               end
            end
            UEF_ENDPOINT_RECEIVE_STATUS_OFS: begin
               if (rx_ok) begin
                  s_nxt.rdata[UEF_B_TOGGLE] = s_r.ep[sel].rx_tog;
               end
               // Overwrite bit always reads zero
               if (sel == 2'd0) begin
                  s_nxt.rdata[UEF_B_SETUP] = s_r.setup;
                  s_nxt.rdata[UEF_B_SETUP_START_OVERWRITE] = s_r.setup_start_overwrite;
                  s_nxt.rdata[UEF_B_SETUP_END_OVERWRITE] = s_r.setup_end_overwrite;
               end
            end
            UEF_RECEIVE_FIFO_DATA_OFS: begin
               if (rx_ok) begin
                  s_nxt.rdata = s_r.ep[sel].rx_mem[s_r.ep[sel].rx_rd];
                  if ({1'b0, s_r.ep[sel].rx_rd} < s_r.ep[sel].rx_cnt) begin
                     s_nxt.ep[sel].rx_rd = s_r.ep[sel].rx_rd + 3'h1;
                  end
               end
            end
            UEF_RECEIVE_BYTE_COUNT_OFS: begin
               if (rx_ok) begin
                  s_nxt.rdata = {4'h0, s_r.ep[sel].rx_cnt};
               end
            end
            UEF_EPSEL_OFS: begin
               s_nxt.rdata = {6'h00, s_r.sel};
            end
            UEF_ENDPOINT_TRANSMIT_STATUS_OFS: begin
               if (tx_ok) begin
                  s_nxt.rdata[UEF_B_TOGGLE] = s_r.ep[sel].tx_tog;
                  s_nxt.rdata[UEF_B_TX_ERR] = s_r.ep[sel].tx_err;
               end
            end
            UEF_TRANSMIT_FIFO_CONTROL_OFS: begin
               if (tx_ok) begin
                  s_nxt.rdata[UEF_B_RELEASE] = s_r.ep[sel].tx_ready;
               end
            end
            UEF_DEVCTL_OFS: begin
               s_nxt.rdata[UEF_B_EP2_DIR] = s_r.ep2_dir;
            end
            UEF_LPMSTAT_OFS: begin
               s_nxt.rdata = {3'h0, s_r.lpm};
            end
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end

      // Register writes
      if (WR) begin
         unique case (ADDR)
            UEF_ENDPOINT_CONTROL_OFS: begin
               if (rx_ok) begin
                  s_nxt.ep[sel].rx_stall = WDATA[UEF_B_RX_STALL];
                  s_nxt.ep[sel].rx_on    = WDATA[UEF_B_RX_ON];
               end
               if (tx_ok) begin
                  s_nxt.ep[sel].tx_stall = WDATA[UEF_B_TX_STALL];
                  s_nxt.ep[sel].tx_on    = WDATA[UEF_B_TX_ON];
               end
            end
            UEF_ENDPOINT_RECEIVE_STATUS_OFS: begin
               if (rx_ok && WDATA[UEF_B_TOG_OVW]) begin
                  s_nxt.ep[sel].rx_tog = WDATA[UEF_B_TOGGLE];
               end
               if (sel == 2'd0) begin
                  if (WDATA[UEF_B_SETUP]) begin
                     s_nxt.setup = 1'b0;
                  end
                  if (WDATA[UEF_B_SETUP_END_OVERWRITE]) begin
                     s_nxt.setup_end_overwrite = 1'b0;
                  end
               end
            end
            UEF_RECEIVE_FIFO_CONTROL_OFS: begin
               if (rx_ok) begin
                  // Flush finishes in this cycle, so the bit never stands
                  if (WDATA[UEF_B_FLUSH]) begin
                     s_nxt.ep[sel].rx_cnt  = 4'h0;
                     s_nxt.ep[sel].rx_rd   = 3'h0;
                     s_nxt.ep[sel].rx_full = 1'b0;
                  end else if (WDATA[UEF_B_RELEASE] &&
                     !(sel == 2'd0 && (s_r.setup_start_overwrite || s_r.setup_end_overwrite))) begin
                     s_nxt.ep[sel].rx_cnt  = 4'h0;
                     s_nxt.ep[sel].rx_rd   = 3'h0;
                     s_nxt.ep[sel].rx_full = 1'b0;
                  end
               end
            end
            UEF_EPSEL_OFS: begin
               s_nxt.sel = WDATA[1:0];
            end
            UEF_ENDPOINT_TRANSMIT_STATUS_OFS: begin
               if (tx_ok) begin
                  if (WDATA[UEF_B_TOG_OVW]) begin
                     s_nxt.ep[sel].tx_tog = WDATA[UEF_B_TOGGLE];
                  end
                  if (WDATA[UEF_B_TX_ERR]) begin
                     s_nxt.ep[sel].tx_err = 1'b0;
                  end
               end
            end
            UEF_TRANSMIT_FIFO_DATA_OFS: begin
               // Bytes beyond the FIFO or into a ready packet are dropped
               if (tx_ok && !s_r.ep[sel].tx_ready &&
                  s_r.ep[sel].tx_cnt < UEF_FIFO_FULL) begin
                  s_nxt.ep[sel].tx_mem[s_r.ep[sel].tx_cnt[2:0]] = WDATA;
                  s_nxt.ep[sel].tx_cnt = s_r.ep[sel].tx_cnt + 4'h1;
               end
            end
            UEF_TRANSMIT_FIFO_CONTROL_OFS: begin
               if (tx_ok) begin
                  if (WDATA[UEF_B_FLUSH]) begin
                     s_nxt.ep[sel].tx_cnt   = 4'h0;
                     s_nxt.ep[sel].tx_rd    = 3'h0;
                     s_nxt.ep[sel].tx_ready = 1'b0;
                  end else if (WDATA[UEF_B_RELEASE]) begin
                     s_nxt.ep[sel].tx_ready = 1'b1;
                  end
               end
            end
            UEF_DEVCTL_OFS: begin
               s_nxt.ep2_dir = WDATA[UEF_B_EP2_DIR];
            end
            default: begin
               s_nxt.sel = s_nxt.sel;
            end
         endcase
      end

      // Link events come after the bus so they win over a bus write in the same cycle
      if (LINK_IN.tok) begin
         s_nxt.cur_ep   = te;
         s_nxt.cur_kind = LINK_IN.kind;
         s_nxt.cur_ok   = 1'b0;
         s_nxt.hs.valid = 1'b1;
         s_nxt.hs.code  = UEF_HS_NONE;
         unique case (LINK_IN.kind)
            UEF_TOK_SETUP: begin
               if (te == 2'd0) begin
                  s_nxt.setup_start_overwrite          = 1'b1;
                  s_nxt.ep[0].rx_cnt   = 4'h0;
                  s_nxt.ep[0].rx_rd    = 3'h0;
                  s_nxt.ep[0].rx_full  = 1'b0;
                  s_nxt.cur_ok         = 1'b1;
                  s_nxt.hs.code        = UEF_HS_ACK;
               end
            end
            UEF_TOK_OUT: begin
               if (has_rx(te, s_r.ep2_dir) && s_r.ep[te].rx_on) begin
                  if (s_r.ep[te].rx_stall) begin
                     s_nxt.hs.code = s_r.setup ? UEF_HS_NAK : UEF_HS_STALL;
                  end else if (s_r.ep[te].rx_full) begin
                     s_nxt.hs.code = UEF_HS_NAK;
                  end else begin
                     s_nxt.hs.code = UEF_HS_ACK;
                     s_nxt.cur_ok  = 1'b1;
                     s_nxt.ep[te].rx_cnt = 4'h0;
                     s_nxt.ep[te].rx_rd  = 3'h0;
                  end
               end
            end
            UEF_TOK_IN: begin
               if (has_tx(te, s_r.ep2_dir) && s_r.ep[te].tx_on) begin
                  if (s_r.ep[te].tx_stall) begin
                     s_nxt.hs.code = s_r.setup ? UEF_HS_NAK : UEF_HS_STALL;
                  end else if (!s_r.ep[te].tx_ready) begin
                     s_nxt.hs.code = UEF_HS_NAK;
                  end else begin
                     s_nxt.hs.code      = UEF_HS_ACK;
                     s_nxt.cur_ok       = 1'b1;
                     s_nxt.ep[te].tx_rd = 3'h0;
                     s_nxt.tx_odd       = s_r.ep[te].tx_tog;
                  end
               end
            end
            default: begin
               s_nxt.hs.code = UEF_HS_NONE;
            end
         endcase
      end else begin
         if (LINK_IN.rx_stb && s_r.cur_ok && s_r.cur_kind != UEF_TOK_IN
            && s_r.ep[ce].rx_cnt < UEF_FIFO_FULL) begin
            s_nxt.ep[ce].rx_mem[s_r.ep[ce].rx_cnt[2:0]] = LINK_IN.rx_byte;
            s_nxt.ep[ce].rx_cnt = s_r.ep[ce].rx_cnt + 4'h1;
         end
         if (LINK_IN.rx_end && s_r.cur_ok &&
            s_r.cur_kind != UEF_TOK_IN) begin
            s_nxt.cur_ok         = 1'b0;
            s_nxt.ep[ce].rx_full = 1'b1;
            if (s_r.cur_kind == UEF_TOK_SETUP) begin
               s_nxt.setup = 1'b1;
               s_nxt.setup_end_overwrite = 1'b1;
               s_nxt.setup_start_overwrite = 1'b0;
            end else begin
               s_nxt.ep[ce].rx_tog = ~s_r.ep[ce].rx_tog;
            end
         end
         if (LINK_IN.tx_take && s_r.cur_ok &&
            s_r.cur_kind == UEF_TOK_IN) begin
            s_nxt.tx_byte      = s_r.ep[ce].tx_mem[s_r.ep[ce].tx_rd];
            s_nxt.ep[ce].tx_rd = s_r.ep[ce].tx_rd + 3'h1;
         end
         if (LINK_IN.in_ack && s_r.cur_ok &&
            s_r.cur_kind == UEF_TOK_IN) begin
            s_nxt.cur_ok          = 1'b0;
            s_nxt.ep[ce].tx_tog   = ~s_r.ep[ce].tx_tog;
            s_nxt.ep[ce].tx_ready = 1'b0;
            s_nxt.ep[ce].tx_cnt   = 4'h0;
            s_nxt.ep[ce].tx_rd    = 3'h0;
         end
         if (LINK_IN.tx_tmo && s_r.cur_kind == UEF_TOK_IN &&
            has_tx(ce, s_r.ep2_dir)) begin
            s_nxt.cur_ok        = 1'b0;
            s_nxt.ep[ce].tx_err = 1'b1;
         end
      end
      if (LINK_IN.lpm_ack) begin
         s_nxt.lpm = LINK_IN.lpm_attr;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST || USB_RST) begin
         s_r <= UEF_STATE_RST;
      end else if (CE) begin
         s_r <= s_nxt;
      end
   end

   assign RDATA      = s_r.rdata;
   assign HS         = s_r.hs;
   assign TX_BYTE    = s_r.tx_byte;
   assign TX_PID_ODD = s_r.tx_odd;

endmodule : uef_endpoint_regs

/* verification/uef_endpoint_regs_sva.sv */
// Assertion checker for the endpoint FIFO register block
`timescale 1ns/1ps
module uef_endpoint_regs_sva
   import uef_pkg::*;
(
   input wire logic            CLK,        // System clock
   input wire logic            SYS_RST,    // System reset
   input wire logic            USB_RST,    // Bus reset
   input wire logic            CE,         // Clock enable
   input wire logic [7:0]      ADDR,       // Register address
   input wire logic [7:0]      WDATA,      // Write data
   input wire logic            WR,         // Write strobe
   input wire logic            RD,         // Read strobe
   input wire logic [7:0]      RDATA,      // Read data
   input wire uef_link_in_type LINK_IN,    // Link events
   input wire uef_hs_type      HS,         // Handshake verdict
   input wire logic [7:0]      TX_BYTE,    // Byte to link
   input wire logic            TX_PID_ODD  // Data PID toggle
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST || USB_RST);

   a_rdata_idle: assert property (
      CE && !RD |=> RDATA == 8'h00) else $error("read data not idle");
   a_hs_quiet: assert property (
      CE && !LINK_IN.tok |=> !HS.valid) else $error("stray handshake");
   a_setup_ack: assert property (
      CE && LINK_IN.tok && LINK_IN.kind == UEF_TOK_SETUP &&
      LINK_IN.ep == 2'b00 |=> HS.valid && HS.code == UEF_HS_ACK)
      else $error("setup not acknowledged");
   a_bad_ep: assert property (
      CE && LINK_IN.tok && LINK_IN.ep == 2'b11
      |=> !(HS.valid && HS.code != UEF_HS_NONE))
      else $error("reserved endpoint answered");
   a_txbyte_hold: assert property (
      CE && !LINK_IN.tx_take |=> $stable(TX_BYTE))
      else $error("transmit byte moved");
   a_pid_hold: assert property (
      CE && !LINK_IN.tok |=> $stable(TX_PID_ODD))
      else $error("pid toggle moved");
   a_ovw_zero: assert property (
      CE && RD && (ADDR == UEF_ENDPOINT_RECEIVE_STATUS_OFS || ADDR == UEF_ENDPOINT_TRANSMIT_STATUS_OFS)
      |=> !RDATA[UEF_B_TOG_OVW]) else $error("overwrite bit read 1");
   a_receive_fifo_control_zero: assert property (
      CE && RD && ADDR == UEF_RECEIVE_FIFO_CONTROL_OFS |=> RDATA == 8'h00)
      else $error("receive control read nonzero");
   a_sel_rsvd: assert property (
      CE && RD && ADDR == UEF_EPSEL_OFS |=> RDATA[7:2] == 6'h00)
      else $error("select reserved bits set");
   a_lpm_rsvd: assert property (
      CE && RD && ADDR == UEF_LPMSTAT_OFS |=> RDATA[7:5] == 3'h0)
      else $error("power status reserved bits set");
   a_cnt_max: assert property (
      CE && RD && ADDR == UEF_RECEIVE_BYTE_COUNT_OFS |=> RDATA <= 8'h08)
      else $error("byte count above depth");

   c_setup: cover property (LINK_IN.tok && LINK_IN.kind == UEF_TOK_SETUP);
   c_ack: cover property (HS.valid && HS.code == UEF_HS_ACK);
   c_stall: cover property (HS.valid && HS.code == UEF_HS_STALL);
   c_lpm: cover property (LINK_IN.lpm_ack);
endmodule : uef_endpoint_regs_sva

bind uef_endpoint_regs uef_endpoint_regs_sva u_sva (
   .CLK(CLK), .SYS_RST(SYS_RST), .USB_RST(USB_RST), .CE(CE),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .LINK_IN(LINK_IN), .HS(HS), .TX_BYTE(TX_BYTE),
   .TX_PID_ODD(TX_PID_ODD));

/* verification/uef_host_model.sv */
// Behavioural USB host issuing link events to the register block
`timescale 1ns/1ps
module uef_host_model
   import uef_pkg::*;
(
   input  wire logic            CLK,     // System clock
   output      uef_link_in_type LINK_IN  // Link events toward block
);
   initial LINK_IN = '0;

   // One pulse; the released byte lane shows the inverse of the last
   task automatic ev(input uef_link_in_type v);
      uef_link_in_type idle;
      idle = '0;
      idle.rx_byte = ~v.rx_byte;
      @(posedge CLK);
      LINK_IN <= v;
      @(posedge CLK);
      LINK_IN <= idle;
   endtask : ev

   task automatic tok(input uef_tok_type k, input logic [1:0] ep);
      uef_link_in_type v;
      v = '0;
      v.tok = 1'b1;
      v.kind = k;
      v.ep = ep;
      ev(v);
   endtask : tok

   task automatic data(input logic [7:0] b);
      uef_link_in_type v;
      v = '0;
      v.rx_stb = 1'b1;
      v.rx_byte = b;
      ev(v);
   endtask : data

   // 0 end of data, 1 take byte, 2 host ack, 3 timeout
   task automatic sig(input logic [1:0] w);
      uef_link_in_type v;
      v = '0;
      v.rx_end = (w == 2'd0);
      v.tx_take = (w == 2'd1);
      v.in_ack = (w == 2'd2);
      v.tx_tmo = (w == 2'd3);
      ev(v);
   endtask : sig

   task automatic lpm(input logic [4:0] a);
      uef_link_in_type v;
      v = '0;
      v.lpm_ack = 1'b1;
      v.lpm_attr = a;
      ev(v);
   endtask : lpm
endmodule : uef_host_model

/* verification/tb_usb_endpoint_fifo_regs.sv */
// Self-checking testbench for the endpoint FIFO register block
`timescale 1ns/1ps
module tb_usb_endpoint_fifo_regs
   import uef_pkg::*;
;
   logic            CLK, SYS_RST, USB_RST, CE, WR, RD, TX_PID_ODD;
   logic [7:0]      ADDR, WDATA, RDATA, TX_BYTE;
   uef_link_in_type link;
   uef_hs_type      hs;
   int              fails, n_checks;
   logic [4:0]      lpm_tab [3] = '{5'h1b, 5'h04, 5'h1f};

   uef_host_model host (.CLK(CLK), .LINK_IN(link));
   uef_endpoint_regs dut (.CLK(CLK), .SYS_RST(SYS_RST), .USB_RST(USB_RST),
      .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .LINK_IN(link), .HS(hs), .TX_BYTE(TX_BYTE),
      .TX_PID_ODD(TX_PID_ODD));

   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   task automatic chk(input string n, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_hs(input string n, input uef_hs_code_type e);
      n_checks++;
      if ({hs.valid, hs.code} !== {1'b1, e}) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, {1'b1, e}, hs);
      end
   endtask : chk_hs

   task automatic wr(input logic [7:0] a, d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, m, e, input string n);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(n, e, RDATA & m);
   endtask : rdc

   task automatic tokc(input uef_tok_type k, input logic [1:0] ep,
                       input uef_hs_code_type e, input string n);
      host.tok(k, ep);
      #1 chk_hs(n, e);
   endtask : tokc

   task automatic t_reset;
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h05, "ep0 control");
      rdc(UEF_EPSEL_OFS, 8'hff, 8'h00, "select");
      rdc(UEF_RECEIVE_BYTE_COUNT_OFS, 8'hff, 8'h00, "count");
      rdc(UEF_LPMSTAT_OFS, 8'hff, 8'h00, "lpm");
      wr(UEF_EPSEL_OFS, 8'h01);
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h00, "ep1 control");
      wr(UEF_EPSEL_OFS, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_setup;
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'hc5);
      tokc(UEF_TOK_SETUP, 2'd0, UEF_HS_ACK, "setup hs");
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h70, 8'h20, "start ovw");
      for (int i = 0; i < 8; i++) host.data(8'h10 + 8'(i));
      host.sig(2'd0);
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h70, 8'h50, "setup flags");
      rdc(UEF_RECEIVE_BYTE_COUNT_OFS, 8'hff, 8'h08, "setup count");
      tokc(UEF_TOK_OUT, 2'd0, UEF_HS_NAK, "out nak");
      tokc(UEF_TOK_IN, 2'd0, UEF_HS_NAK, "in nak");
      wr(UEF_RECEIVE_FIFO_CONTROL_OFS, 8'h10);
      rdc(UEF_RECEIVE_FIFO_DATA_OFS, 8'hff, 8'h10, "byte 0");
      wr(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h50);
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h70, 8'h00, "flags clr");
      rdc(UEF_RECEIVE_BYTE_COUNT_OFS, 8'hff, 8'h08, "held count");
      for (int i = 1; i < 8; i++)
         rdc(UEF_RECEIVE_FIFO_DATA_OFS, 8'hff, 8'h10 + 8'(i), "byte");
      tokc(UEF_TOK_OUT, 2'd0, UEF_HS_STALL, "out stall");
      tokc(UEF_TOK_IN, 2'd0, UEF_HS_STALL, "in stall");
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'h05);
      $display("test setup done");
   endtask : t_setup

   task automatic t_out;
      wr(UEF_RECEIVE_FIFO_CONTROL_OFS, 8'h10);
      tokc(UEF_TOK_OUT, 2'd0, UEF_HS_ACK, "out ack");
      for (int i = 0; i < 3; i++) host.data(8'h30 + 8'(i));
      host.sig(2'd0);
      rdc(UEF_RECEIVE_BYTE_COUNT_OFS, 8'hff, 8'h03, "out count");
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h80, 8'h80, "rx toggle");
      tokc(UEF_TOK_OUT, 2'd0, UEF_HS_NAK, "held nak");
      wr(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h00);
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h88, 8'h80, "no ovw");
      wr(UEF_RECEIVE_FIFO_CONTROL_OFS, 8'h80);
      rdc(UEF_RECEIVE_BYTE_COUNT_OFS, 8'hff, 8'h00, "flush count");
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h80, 8'h80, "flush tog");
      wr(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h08);
      rdc(UEF_ENDPOINT_RECEIVE_STATUS_OFS, 8'h80, 8'h00, "ovw write");
      $display("test out done");
   endtask : t_out

   task automatic t_in;
      wr(UEF_EPSEL_OFS, 8'h01);
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'h01);
      tokc(UEF_TOK_IN, 2'd1, UEF_HS_NAK, "not ready");
      wr(UEF_TRANSMIT_FIFO_DATA_OFS, 8'ha1);
      wr(UEF_TRANSMIT_FIFO_DATA_OFS, 8'ha2);
      wr(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h10);
      rdc(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h10, 8'h10, "ready");
      tokc(UEF_TOK_IN, 2'd1, UEF_HS_ACK, "in ack");
      chk("pid even", 8'h00, {7'h0, TX_PID_ODD});
      host.sig(2'd1);
      #1 chk("byte a1", 8'ha1, TX_BYTE);
      host.sig(2'd1);
      #1 chk("byte a2", 8'ha2, TX_BYTE);
      host.sig(2'd2);
      rdc(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h80, 8'h80, "tx toggle");
      rdc(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h10, 8'h00, "ready clr");
      wr(UEF_TRANSMIT_FIFO_DATA_OFS, 8'ha3);
      wr(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h10);
      tokc(UEF_TOK_IN, 2'd1, UEF_HS_ACK, "in ack 2");
      chk("pid odd", 8'h01, {7'h0, TX_PID_ODD});
      host.sig(2'd3);
      rdc(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h82, 8'h82, "tx err");
      wr(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h02);
      rdc(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h82, 8'h80, "err clr");
      wr(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h80);
      rdc(UEF_TRANSMIT_FIFO_CONTROL_OFS, 8'h10, 8'h00, "tx flush");
      rdc(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h80, 8'h80, "flush tog");
      wr(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h08);
      wr(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h80);
      rdc(UEF_ENDPOINT_TRANSMIT_STATUS_OFS, 8'h80, 8'h00, "tog guard");
      $display("test in done");
   endtask : t_in

   task automatic t_ep2;
      wr(UEF_EPSEL_OFS, 8'h02);
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'hc5);
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h41, "ep2 tx ctl");
      rdc(UEF_DEVCTL_OFS, 8'h01, 8'h00, "dir reset");
      wr(UEF_DEVCTL_OFS, 8'h01);
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h00, "ep2 rx ctl");
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'hc5);
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h84, "ep2 rx set");
      wr(UEF_EPSEL_OFS, 8'h03);
      wr(UEF_ENDPOINT_CONTROL_OFS, 8'hc5);
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h00, "no ep");
      for (int i = 0; i < 3; i++) begin
         host.lpm(lpm_tab[i]);
         rdc(UEF_LPMSTAT_OFS, 8'hff, {3'h0, lpm_tab[i]}, "lpm");
      end
      $display("test ep2 and lpm done");
   endtask : t_ep2

   task automatic t_usb_rst;
      @(posedge CLK);
      CE <= 1'b0;
      wr(UEF_EPSEL_OFS, 8'h01);
      @(posedge CLK);
      CE <= 1'b1;
      rdc(UEF_EPSEL_OFS, 8'hff, 8'h03, "frozen");
      @(posedge CLK);
      USB_RST <= 1'b1;
      @(posedge CLK);
      USB_RST <= 1'b0;
      rdc(UEF_EPSEL_OFS, 8'hff, 8'h00, "bus rst sel");
      rdc(UEF_ENDPOINT_CONTROL_OFS, 8'hff, 8'h05, "bus rst ep0");
      rdc(UEF_DEVCTL_OFS, 8'h01, 8'h00, "bus rst dir");
      $display("test bus reset done");
   endtask : t_usb_rst

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge CLK);
      fails++;
      end_of_test();
   end

   initial begin
      SYS_RST = 1'b1;
      USB_RST = 1'b0;
      CE = 1'b1;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 8'h00;
      WDATA = 8'h00;
      fails = 0;
      n_checks = 0;
      repeat (10) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_reset();
      t_setup();
      t_out();
      t_in();
      t_ep2();
      t_usb_rst();
      end_of_test();
   end
endmodule : tb_usb_endpoint_fifo_regs
